// ### hw/ffj_judge.sv
// Purpose: free-fall judge on the zero-gravity flag pulse width
// Assumes: flag arrives asynchronously from the sensor pin
// Notes: judging time from an 8-bit switch, scaled to the counter
module ffj_judge #(
	parameter int unsigned CNT_W = ffj_pkg::CNT_WIDTH,
	parameter int unsigned FILT = ffj_pkg::FILT_LEN
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	// sensor side
	input wire logic i_zero_gravity_flag,
	input wire logic i_run,
	// judging time switch
	input wire logic [ffj_pkg::SW_WIDTH-1:0] i_judge_sw,
	// outputs
	output ffj_pkg::ffj_out_s o_status,
	output logic [CNT_W-1:0] o_flag_pulse_width
);
	localparam int unsigned SW_W = ffj_pkg::SW_WIDTH;

	// ************************************************************
	// parameter checks
	// ************************************************************
	// the filter shifts at least two samples, and the switch needs
	// spare low bits below it in the counter
	initial begin
		if (CNT_W <= SW_W) $error("ffj_judge: CNT_W must exceed switch width");
		if (FILT < 2 || FILT > 32) $error("ffj_judge: FILT out of range");
		if (64'(ffj_pkg::SYS_CLK_HZ / ffj_pkg::TICK_DIV) >= ffj_pkg::CNT_CLK_MAX_HZ) begin
			$error("ffj_judge: counting tick too fast for the counter");
		end
	end

	// ************************************************************
	// input synchronisers
	// ************************************************************
	// flag, run and switch are asynchronous levels: two flops each;
	// a switch word caught mid-move settles a cycle later, harmless
	logic [1:0] flag_sync;
	logic [SW_W-1:0] sw_meta;
	logic [SW_W-1:0] sw_sync;
	logic [1:0] run_sync;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_sync <= 2'b00;
			sw_meta <= ffj_pkg::SW_RESET;
			sw_sync <= ffj_pkg::SW_RESET;
			run_sync <= 2'b00;
		end else if (i_ce) begin
			flag_sync <= {flag_sync[0], i_zero_gravity_flag};
			sw_meta <= i_judge_sw;
			sw_sync <= sw_meta;
			run_sync <= {run_sync[0], i_run};
		end
	end

	// ************************************************************
	// chatter filter
	// ************************************************************
	// a flag that stays put for FILT samples is accepted; a little
	// latency traded for immunity to short glitches
	logic [FILT-1:0] filt_hist;
	logic [FILT-1:0] next_filt_hist;
	logic flag_clean;
	logic next_flag_clean;

	// glitches shorter than FILT samples leave the clean flag alone
	// chatter filter, always in the flag path
	always_comb begin
		next_filt_hist = {filt_hist[FILT-2:0], flag_sync[1]};
		next_flag_clean = flag_clean;
		if (&next_filt_hist) begin
			next_flag_clean = 1'b1;
		end else if (~|next_filt_hist) begin
			next_flag_clean = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			filt_hist <= '0;
			flag_clean <= 1'b0;
		end else if (i_ce) begin
			filt_hist <= next_filt_hist;
			flag_clean <= next_flag_clean;
		end
	end

	// ************************************************************
	// counting tick
	// ************************************************************
	// divider runs freely, so the first tick of a pulse comes
	// anywhere within one tick period: width error under one tick
	logic tick;

	ffj_tick_div #(
		.DIV(ffj_pkg::TICK_DIV)
	) u_tick (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.o_tick(tick)
	);

	// ************************************************************
	// count and compare
	// ************************************************************
	// switch value sits in the upper bits: 0..255 steps of 2^(CNT_W-8)
	// ticks, so the full switch range spans the counter range
	logic [CNT_W-1:0] judge_limit;
	// limit from switch setting
	// limitation: moving the switch mid-pulse moves the limit at once
	assign judge_limit = {sw_sync, {(CNT_W - SW_W){1'b0}}};

	ffj_pkg::ffj_state_e state;
	ffj_pkg::ffj_state_e next_state;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	ffj_pkg::ffj_out_s next_status;

	always_comb begin
		next_state = state;
		next_count = count;
		next_status = o_status;
		next_status.standby_control_n = run_sync[1];
		case (state)
			ffj_pkg::FFJ_IDLE: begin
				next_count = ffj_pkg::COUNT_RESET;
				next_status.alarm_irq = 1'b0;
				next_status.lamp_on = 1'b0;
				// limitation: run low blocks a new count, not a running one
				// restart from zero on rise
				if (flag_clean && run_sync[1]) begin
					next_state = ffj_pkg::FFJ_COUNT;
				end
			end
			ffj_pkg::FFJ_COUNT: begin
				if (!flag_clean) begin
					next_state = ffj_pkg::FFJ_IDLE;
					next_count = ffj_pkg::COUNT_RESET;
				end else if (count >= judge_limit) begin
					// >= so a limit lowered mid-count still trips
					// compare against judging time
					next_state = ffj_pkg::FFJ_ALARM;
					next_status.alarm_irq = 1'b1;
					next_status.lamp_on = 1'b1;
				end else if (tick) begin
					next_count = count + CNT_W'(1);
				end
			end
			ffj_pkg::FFJ_ALARM: begin
				// count frozen at the match for a reader of the width
				// hold alarm, count stopped
				if (!flag_clean) begin
					next_state = ffj_pkg::FFJ_IDLE;
					next_count = ffj_pkg::COUNT_RESET;
					next_status.alarm_irq = 1'b0;
					next_status.lamp_on = 1'b0;
				end
			end
			default: begin
				// unused code: back to a safe idle
				next_state = ffj_pkg::FFJ_IDLE;
				next_count = ffj_pkg::COUNT_RESET;
			end
		endcase
	end

	// ************************************************************
	// state and output registers
	// ************************************************************
	// every port comes from a flop; a reset drops the alarm even
	// while the flag stands
	// autonomous state update
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ffj_pkg::FFJ_IDLE;
			count <= ffj_pkg::COUNT_RESET;
			o_status <= '0;
			o_flag_pulse_width <= ffj_pkg::COUNT_RESET;
		end else if (i_ce) begin
			state <= next_state;
			count <= next_count;
			o_status <= next_status;
			o_flag_pulse_width <= next_count;
		end
	end
endmodule : ffj_judge

// ### shared/ffj_pkg.sv
// Purpose: constants and types for the free-fall pulse judge
// Assumes: 100 MHz system clock
// Notes: judging time counted in ticks of a divided counting clock
package ffj_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned SYS_CLK_HZ = 100_000_000;
	localparam int unsigned CNT_WIDTH = 16;
	localparam int unsigned JUDGE_TIME_MS = 100;
	// counting clock ceiling: 2^width / judging time, in Hz
	localparam longint unsigned CNT_CLK_MAX_HZ = (64'(1) << CNT_WIDTH) * 1000 / JUDGE_TIME_MS;
	// divider ratio rounded up so the tick rate stays below the ceiling
	localparam int unsigned TICK_DIV = int'((64'(SYS_CLK_HZ) + CNT_CLK_MAX_HZ - 1) / CNT_CLK_MAX_HZ) + 1;
	localparam int unsigned SW_WIDTH = 8;
	localparam int unsigned FILT_LEN = 4;
	localparam logic [SW_WIDTH-1:0] SW_RESET = 8'h00;
	localparam logic [CNT_WIDTH-1:0] COUNT_RESET = 16'h0000;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		FFJ_IDLE = 2'b00,
		FFJ_COUNT = 2'b01,
		FFJ_ALARM = 2'b11
	} ffj_state_e;

	typedef struct packed {
		logic alarm_irq;
		logic lamp_on;
		logic standby_control_n;
	} ffj_out_s;
endpackage : ffj_pkg

// ### hw/ffj_tick_div.sv
// Purpose: counting clock enable divided from the main clock
// Assumes: one tick pulse every DIV cycles of i_clk_sys
// Notes: a tick enable, not a derived clock, to keep one domain
module ffj_tick_div #(
	parameter int unsigned DIV = ffj_pkg::TICK_DIV
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	// tick
	output logic o_tick
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	initial begin
		if (DIV < 2) $error("ffj_tick_div: DIV must be at least 2");
	end

	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_cnt = cnt + W'(1);
		next_tick = 1'b0;
		if (cnt == LAST) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= '0;
			o_tick <= 1'b0;
		end else if (i_ce) begin
			cnt <= next_cnt;
			o_tick <= next_tick;
		end
	end
endmodule : ffj_tick_div

// ### tb/ffj_judge_assertions.sv
// Purpose: port checker for the free-fall judge
// Assumes: one clock, async active-low reset
// Notes: sync plus filter delay taken as under 8 edges
module ffj_judge_assertions #(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned FILT = 4
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// inputs
	input wire logic i_ce,
	input wire logic i_zero_gravity_flag,
	input wire logic i_run,
	input wire logic [ffj_pkg::SW_WIDTH-1:0] i_judge_sw,
	// outputs
	input wire ffj_pkg::ffj_out_s o_status,
	input wire logic [CNT_W-1:0] o_flag_pulse_width
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	// ****
	// checks
	// ****
	a_lamp_tracks: assert property (o_status.lamp_on == o_status.alarm_irq)
		else $error("lamp differs from alarm");
	a_count_step: assert property (o_flag_pulse_width == $past(o_flag_pulse_width) ||
		o_flag_pulse_width == $past(o_flag_pulse_width) + 1'b1 || o_flag_pulse_width == '0)
		else $error("count jumped");
	a_low_clears: assert property ((!i_zero_gravity_flag && i_ce)[*8] |=> o_flag_pulse_width == '0)
		else $error("count not cleared");
	a_low_no_alarm: assert property ((!i_zero_gravity_flag && i_ce)[*8] |=> !o_status.alarm_irq)
		else $error("alarm kept after fall");
	a_alarm_holds: assert property (i_zero_gravity_flag[*8] ##0 o_status.alarm_irq |=> o_status.alarm_irq)
		else $error("alarm dropped");
	a_count_stops: assert property (o_status.alarm_irq ##1 o_status.alarm_irq |-> $stable(o_flag_pulse_width))
		else $error("count moved in alarm");
	a_zero_sw_match: assert property ((i_zero_gravity_flag && i_ce && i_run && i_judge_sw == 8'h00)[*8]
		|-> ##[0:12] o_status.alarm_irq)
		else $error("no alarm on zero limit");
	a_ce_freeze: assert property (!i_ce |=> $stable(o_flag_pulse_width) && $stable(o_status))
		else $error("state moved without enable");
	a_standby_copy: assert property (i_ce[*4] |-> o_status.standby_control_n == $past(i_run, 3))
		else $error("standby drive wrong");
	c_alarm: cover property ($rose(o_status.alarm_irq));
	c_count: cover property (o_flag_pulse_width == 16'h0002);
	c_standby: cover property (!o_status.standby_control_n);
endmodule : ffj_judge_assertions

bind ffj_judge ffj_judge_assertions #(.CNT_W(CNT_W), .FILT(FILT)) u_chk (.i_clk_sys, .i_rstn, .i_ce,
	.i_zero_gravity_flag, .i_run, .i_judge_sw, .o_status, .o_flag_pulse_width);

// ### tb/ffj_sensor_model.sv
// Purpose: behavioural sensor flag source
// Assumes: EVAL cycles stand in for the re-evaluation period
// Notes: a short period keeps runs brief
module ffj_sensor_model #(
	parameter int unsigned EVAL = 3
) (
	// clock
	input wire logic i_clk_sys,
	// control
	input wire logic i_near_zero,
	input wire logic i_standby_control_n,
	// flag
	output logic o_zero_gravity_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned n = 0;
	initial o_zero_gravity_flag = 1'b0;
	// rising edge, so the bench's falling-edge stimulus is settled
	// flag at each evaluation
	always @(posedge i_clk_sys) begin
		n = (n + 1) % EVAL;
		if (n == 0) begin
			o_zero_gravity_flag <= i_near_zero && i_standby_control_n;
		end
	end
endmodule : ffj_sensor_model

// ### tb/freefall_pulse_judge_tb_top.sv
// Purpose: self-checking bench for the free-fall judge
// Assumes: inputs change on the falling edge
// Notes: only limit 0 alarms in time; larger limits need too many ticks
`define CHK(n, e, s) begin \
	checked++; \
	if ((s) !== (e)) begin \
		num_errors++; \
		$display("BAD %s exp %0h got %0h", n, e, s); \
	end \
end
module freefall_pulse_judge_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic near = 1'b0;
	logic run = 1'b1;
	logic flag;
	logic [7:0] sw = 8'h00;
	ffj_pkg::ffj_out_s st;
	logic [15:0] cnt;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	// ticks over 5000 cycles, less the sync and filter delay
	localparam int unsigned TICKS_LO = (5000 - 20) / ffj_pkg::TICK_DIV;
	localparam int unsigned TICKS_HI = 5000 / ffj_pkg::TICK_DIV + 1;
	// full counter span in ms at the tick rate
	localparam longint unsigned SPAN_MS = (64'(1) << ffj_pkg::CNT_WIDTH) * ffj_pkg::TICK_DIV * 1000 /
		ffj_pkg::SYS_CLK_HZ;
	ffj_judge DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_zero_gravity_flag(flag),
		.i_run(run), .i_judge_sw(sw), .o_status(st), .o_flag_pulse_width(cnt));
	ffj_sensor_model u_sensor (.i_clk_sys(clk), .i_near_zero(near),
		.i_standby_control_n(st.standby_control_n), .o_zero_gravity_flag(flag));
	initial forever #5 clk = ~clk;
	// ****
	// helpers
	// ****
	function automatic logic exp_alarm(logic [7:0] s, int t);
		return t >= (int'(s) << (ffj_pkg::CNT_WIDTH - ffj_pkg::SW_WIDTH));
	endfunction : exp_alarm
	task automatic wait_cyc(int n);
		repeat (n) @(negedge clk);
	endtask : wait_cyc
	task automatic wrap_up();
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// hang guard well above the planned run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(32'h4F40));
		wait_cyc(4);
		rstn = 1'b1;
		near = 1'b1;
		wait_cyc(40);
		`CHK("alarm", exp_alarm(sw, 0), st.alarm_irq)
		`CHK("lamp", 1'b1, st.lamp_on)
		`CHK("count", 16'h0000, cnt)
		near = 1'b0;
		wait_cyc(20);
		`CHK("alarm", 1'b0, st.alarm_irq)
		sw = 8'h01;
		near = 1'b1;
		wait_cyc(5000);
		`CHK("ticks", 1'b1, cnt inside {[16'(TICKS_LO):16'(TICKS_HI)]})
		`CHK("alarm", exp_alarm(sw, 5000 / ffj_pkg::TICK_DIV), st.alarm_irq)
		near = 1'b0;
		wait_cyc(30);
		`CHK("count", 16'h0000, cnt)
		near = 1'b1;
		wait_cyc(20);
		`CHK("restart", 1'b1, cnt <= 16'h0001)
		repeat (300) begin
			near = 1'($urandom);
			ce = 1'($urandom);
			sw = 8'($urandom_range(255, 1));
			@(negedge clk);
		end
		ce = 1'b1;
		`CHK("alarm", 1'b0, st.alarm_irq)
		`CHK("lamp", 1'b0, st.lamp_on)
		`CHK("span", 1'b1, SPAN_MS >= ffj_pkg::JUDGE_TIME_MS)
		sw = 8'h00;
		run = 1'b0;
		near = 1'b1;
		wait_cyc(30);
		`CHK("standby", 1'b0, st.standby_control_n)
		`CHK("count", 16'h0000, cnt)
		run = 1'b1;
		wait_cyc(40);
		`CHK("alarm", 1'b1, st.alarm_irq)
		rstn = 1'b0;
		wait_cyc(2);
		`CHK("alarm", 1'b0, st.alarm_irq)
		rstn = 1'b1;
		wait_cyc(40);
		`CHK("alarm", 1'b1, st.alarm_irq)
		wrap_up();
	end
endmodule : freefall_pulse_judge_tb_top
